/* hw/dpm_protection_mode.sv */
// protection and maintenance mode logic with register port and interrupt
// Notes on behaviour
// - carrier lowering bit turns overheat/overload into carrier lowering, no trip
// - input phase loss bit set: input loss or unbalance trips with alarm
// - output phase loss bit set: loss while running trips with alarm
// - threshold bit picks factory (0) or user (1) capacitor life level
// - life judgment bit enables judging life from discharge time
// - on-time based life judgment always continues
// - fan lock bit zero: fan lock raises heat sink alarm, coast stop
// - fan lock drives overheat and life warnings whatever the fan lock bit, except with the fan commanded off as below
// - fan commanded off under fan control: lock treated normal; start runs fan
// - enclosure bit picks lower (0) or sealed (1) protection class
// - factory init sets bits 0,1,4, clears 2,3,5, enclosure from strap
//
// The plain strobed port and the placing of the registers were left to the implementer.
module dpm_protection_mode (
	// clock and reset
	input  wire logic                 REF_CLK,
	input  wire logic                 RESET,
	// register port
	input  wire logic [3:0]           ADDR,
	input  wire logic [7:0]           WDATA,
	input  wire logic                 WR,
	input  wire logic                 RD,
	output logic      [7:0]           RDATA,
	// drive side
	input  wire dpm_pkg::dpm_detect_s DETECT,
	input  wire logic                 ENCL_STRAP,
	input  wire logic                 FAN_ONOFF_CONTROL_SETTING,
	input  wire logic                 START_CMD,
	input  wire logic                 FAN_STOP_REQ,
	input  wire logic                 ALARM_RESET,
	output dpm_pkg::dpm_action_s      ACTION,
	output logic      [7:0]           ALARMS,
	output logic                      IRQ
);
	import dpm_pkg::*;

	logic [7:0]        mode_q, mode_d;
	logic [7:0]        alarm_q, alarm_d;
	logic [7:0]        stat_q, stat_d;
	logic [7:0]        mask_q, mask_d;
	logic [7:0]        rdata_q, rdata_d;
	logic              fan_off_q, fan_off_d;
	logic              init_q, init_d;
	dpm_action_s       act_q, act_d;
	logic [NUM_EV-1:0] ev;
	logic              fan_lock_eff;
	logic              life_hit;

	// a commanded-off fan hides a lock only while fan on/off control is set
	always_comb begin
		fan_lock_eff = DETECT.fan_locked &&
			!(FAN_ONOFF_CONTROL_SETTING && fan_off_q);
		life_hit = DETECT.ontime_expired ||
			(mode_q[BIT_DIS_LIFE] && DETECT.discharge_done &&
			 DETECT.discharge_short);
	end

	// event detection from sampled inputs
	always_comb begin
		ev = '0;
		ev[AL_IN_PL]  = mode_q[BIT_IN_PL] && DETECT.in_phase_loss;
		ev[AL_OUT_PL] = mode_q[BIT_OUT_PL] && DETECT.out_phase_loss &&
			DETECT.running;
		ev[AL_HS_OH]  = (!mode_q[BIT_CARRIER] && DETECT.heat_sink_hot) ||
			(!mode_q[BIT_FAN_LOCK] && fan_lock_eff);
		ev[AL_INT_OH] = !mode_q[BIT_CARRIER] && DETECT.internal_hot;
		ev[AL_OVL]    = !mode_q[BIT_CARRIER] && DETECT.overload;
		ev[AL_LIFE]   = life_hit;
	end

	// mode word, factory load after reset release
	always_comb begin
		mode_d = mode_q;
		init_d = 1'b1;
		if (!init_q) begin
			mode_d = MODE_FACTORY;
			mode_d[BIT_ENCL] = ENCL_STRAP;
		end else if (WR && ADDR == ADDR_MODE) begin
			mode_d = WDATA & MODE_WMASK;
		end
	end

	// alarms latch until alarm reset, status sticky until read
	always_comb begin
		alarm_d = alarm_q;
		if (ALARM_RESET)
			alarm_d = '0;
		alarm_d[NUM_EV-1:0] = alarm_d[NUM_EV-1:0] | ev;
		stat_d = stat_q;
		if (RD && ADDR == ADDR_STATUS)
			stat_d = '0;
		stat_d[NUM_EV-1:0] = stat_d[NUM_EV-1:0] | (ev & ~alarm_q[NUM_EV-1:0]);
		mask_d = mask_q;
		if (WR && ADDR == ADDR_MASK)
			mask_d = WDATA;
		fan_off_d = fan_off_q;
		if (START_CMD)
			fan_off_d = 1'b0;
		else if (FAN_STOP_REQ && FAN_ONOFF_CONTROL_SETTING)
			fan_off_d = 1'b1;
	end

	// outputs toward the power stage
	always_comb begin
		act_d = '0;
		act_d.trip = |alarm_d[AL_OVL:AL_IN_PL];
		act_d.coast = alarm_d[AL_HS_OH] && fan_lock_eff;
		act_d.lower_carrier = mode_q[BIT_CARRIER] && (DETECT.heat_sink_hot ||
			DETECT.internal_hot || DETECT.overload);
		act_d.fan_run_cmd = !fan_off_d;
		act_d.overheat_warning_output = fan_lock_eff ||
			alarm_d[AL_HS_OH];
		act_d.life_warning_output = fan_lock_eff ||
			alarm_d[AL_LIFE];
		act_d.threshold_user = mode_q[BIT_THR_SEL];
		act_d.sealed_enclosure = mode_q[BIT_ENCL];
	end

	// register read mux
	always_comb begin
		rdata_d = '0;
		if (RD) begin
			unique case (ADDR)
				ADDR_MODE:   rdata_d = mode_q & MODE_WMASK;
				ADDR_STATUS: rdata_d = stat_q;
				ADDR_MASK:   rdata_d = mask_q;
				ADDR_ALARM:  rdata_d = alarm_q;
				ADDR_CTRL:   rdata_d = {6'h00, fan_off_q, fan_lock_eff};
				default:     rdata_d = '0;
			endcase
		end
	end

	always_ff @(posedge REF_CLK or posedge RESET) begin
		if (RESET) begin
			mode_q    <= '0;
			init_q    <= 1'b0;
			alarm_q   <= '0;
			stat_q    <= '0;
			mask_q    <= '0;
			rdata_q   <= '0;
			fan_off_q <= 1'b0;
			act_q     <= '0;
		end else begin
			mode_q    <= mode_d;
			init_q    <= init_d;
			alarm_q   <= alarm_d;
			stat_q    <= stat_d;
			mask_q    <= mask_d;
			rdata_q   <= rdata_d;
			fan_off_q <= fan_off_d;
			act_q     <= act_d;
		end
	end

	assign RDATA  = rdata_q;
	assign ACTION = act_q;
	assign ALARMS = alarm_q;
	assign IRQ    = |(stat_q & mask_q);
endmodule // dpm_protection_mode

/* hw/dpm_pkg.sv */
// package: register map, field positions and carrier structs for protection mode logic
package dpm_pkg;
	localparam logic [3:0] ADDR_MODE   = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h1;
	localparam logic [3:0] ADDR_MASK   = 4'h2;
	localparam logic [3:0] ADDR_ALARM  = 4'h3;
	localparam logic [3:0] ADDR_CTRL   = 4'h4;
	localparam int BIT_CARRIER  = 0;
	localparam int BIT_IN_PL    = 1;
	localparam int BIT_OUT_PL   = 2;
	localparam int BIT_THR_SEL  = 3;
	localparam int BIT_DIS_LIFE = 4;
	localparam int BIT_FAN_LOCK = 5;
	localparam int BIT_UNUSED   = 6;
	localparam int BIT_ENCL     = 7;
	// factory word without the enclosure bit
	localparam logic [7:0] MODE_FACTORY = 8'h13;
	localparam logic [7:0] MODE_WMASK   = 8'hbf;
	// alarm and status bit positions
	localparam int AL_IN_PL  = 0;
	localparam int AL_OUT_PL = 1;
	localparam int AL_HS_OH  = 2;
	localparam int AL_INT_OH = 3;
	localparam int AL_OVL    = 4;
	localparam int AL_LIFE   = 5;
	localparam int NUM_EV    = 6;

	typedef struct packed {
		logic in_phase_loss;
		logic out_phase_loss;
		logic heat_sink_hot;
		logic internal_hot;
		logic overload;
		logic fan_locked;
		logic running;
		logic discharge_short;
		logic discharge_done;
		logic ontime_expired;
	} dpm_detect_s;

	typedef struct packed {
		logic trip;
		logic coast;
		logic lower_carrier;
		logic fan_run_cmd;
		logic overheat_warning_output;
		logic life_warning_output;
		logic threshold_user;
		logic sealed_enclosure;
	} dpm_action_s;
endpackage

/* tb/dpm_monitor_model.sv */
// power-stage monitor model: detection levels registered on the clock
module dpm_monitor_model import dpm_pkg::*; (
	input  wire logic       clk,
	input  wire logic [9:0] want,
	output dpm_detect_s     det
);
	timeunit 1ns;
	timeprecision 1ns;
	always_ff @(posedge clk) det <= dpm_detect_s'(want);
endmodule // dpm_monitor_model

/* tb/dpm_protection_mode_sva.sv */
// checker: port-level assertions of the protection mode block
module dpm_chk import dpm_pkg::*; (
	input wire logic        REF_CLK, RESET, RD, ALARM_RESET, IRQ,
	input wire logic [3:0]  ADDR,
	input wire logic [7:0]  RDATA, ALARMS,
	input wire dpm_detect_s DETECT,
	input wire dpm_action_s ACTION
);
	wire d_or = DETECT.out_phase_loss & DETECT.running;
	wire d_ht = DETECT.heat_sink_hot | DETECT.internal_hot | DETECT.overload;
	wire d_hs = DETECT.heat_sink_hot | DETECT.fan_locked;
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (RESET);
	a_bit_six: assert property
		(RD && ADDR == ADDR_MODE |=> !RDATA[6]) else $error("bit six");
	a_alarm_hold: assert property
		(!ALARM_RESET |=> (ALARMS & $past(ALARMS)) == $past(ALARMS))
		else $error("alarm dropped");
	a_in_cause: assert property
		($rose(ALARMS[AL_IN_PL]) |-> $past(DETECT.in_phase_loss))
		else $error("input alarm");
	a_out_run: assert property
		($rose(ALARMS[AL_OUT_PL]) |-> $past(d_or)) else $error("out alarm");
	a_hs_cause: assert property
		($rose(ALARMS[AL_HS_OH]) |-> $past(d_hs)) else $error("hs alarm");
	a_carrier_cause: assert property
		(ACTION.lower_carrier |-> $past(d_ht)) else $error("carrier");
	a_coast_lock: assert property
		($rose(ACTION.coast) |-> $past(DETECT.fan_locked)) else $error("coast");
	a_fan_warn: assert property
		(DETECT.fan_locked && ACTION.fan_run_cmd ##1 ACTION.fan_run_cmd |->
		ACTION.overheat_warning_output && ACTION.life_warning_output)
		else $error("fan warning");
	c_in: cover property (ALARMS[AL_IN_PL]);
	c_lc: cover property (ACTION.lower_carrier);
	c_co: cover property (ACTION.coast);
	c_iq: cover property (IRQ);
endmodule // dpm_chk
bind dpm_protection_mode dpm_chk u_chk (.REF_CLK(REF_CLK), .RESET(RESET),
	.RD(RD), .ALARM_RESET(ALARM_RESET), .IRQ(IRQ), .ADDR(ADDR),
	.RDATA(RDATA), .ALARMS(ALARMS), .DETECT(DETECT), .ACTION(ACTION));

/* tb/tb_drive_protection_mode_logic.sv */
// testbench: mode word, alarms, warnings and interrupt
module tb_drive_protection_mode_logic;
	import dpm_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rst = 1, wr = 0, rd = 0, fc = 0, st = 0, fs = 0, ar = 0;
	logic [3:0] addr = 0;
	logic [7:0] wd = 0, rdata, al;
	logic [9:0] want = 0;
	logic irq;
	dpm_detect_s det;
	dpm_action_s act;
	int errors = 0, comparisons = 0, cyc = 0;
	always #20 clk = ~clk;
	dpm_monitor_model mon (.clk(clk), .want(want), .det(det));
	dpm_protection_mode uut (.REF_CLK(clk), .RESET(rst), .ADDR(addr),
		.WDATA(wd), .WR(wr), .RD(rd), .RDATA(rdata), .DETECT(det),
		.ENCL_STRAP(1'b1), .FAN_ONOFF_CONTROL_SETTING(fc), .START_CMD(st),
		.FAN_STOP_REQ(fs), .ALARM_RESET(ar), .ACTION(act), .ALARMS(al),
		.IRQ(irq));
	task automatic chk(logic [7:0] s, e, string n);
		comparisons++;
		if (s !== e) begin
			errors++;
			$display("mismatch %s exp %h seen %h", n, e, s);
		end
	endtask
	task automatic wreg(logic [3:0] a, logic [7:0] d);
		@(posedge clk) {addr, wd, wr} <= {a, d, 1'b1};
		@(posedge clk) wr <= 0;
	endtask
	task automatic rreg(logic [3:0] a, logic [7:0] e);
		@(posedge clk) {addr, rd} <= {a, 1'b1};
		@(posedge clk) rd <= 0;
		#1 chk(rdata, e, "rdata");
	endtask
	task automatic ev(logic [9:0] v);
		@(posedge clk) want <= v;
		repeat (3) @(posedge clk);
		#1;
	endtask
	task automatic clr;
		// let the monitor drop its levels before the alarm reset
		@(posedge clk) want <= 10'h0;
		@(posedge clk);
		@(posedge clk) ar <= 1'b1;
		@(posedge clk) ar <= 1'b0;
		@(posedge clk);
		#1 chk(al, 8'h00, "cleared");
	endtask
	task automatic t_regs;
		rreg(ADDR_MODE, 8'h93);
		wreg(ADDR_MODE, 8'hff);
		rreg(ADDR_MODE, 8'hbf);
		rreg(4'hf, 8'h00);
	endtask
	task automatic t_in_loss;
		wreg(ADDR_MASK, 8'h01);
		wreg(ADDR_MODE, 8'h02);
		ev(10'h200);
		chk(al, 8'h01, "alarms");
		chk(act.trip, 1'b1, "trip");
		chk(irq, 1'b1, "irq");
		rreg(ADDR_STATUS, 8'h01);
		chk(irq, 1'b0, "irq");
		clr;
		wreg(ADDR_MODE, 8'h00);
		ev(10'h200);
		chk(al, 8'h00, "alarms");
	endtask
	task automatic t_carrier;
		wreg(ADDR_MODE, 8'h01);
		ev(10'h0a0);
		chk(act.lower_carrier, 1'b1, "carrier");
		chk(al, 8'h00, "alarms");
		clr;
		wreg(ADDR_MODE, 8'h00);
		ev(10'h080);
		chk(al, 8'h04, "alarms");
		rreg(ADDR_ALARM, 8'h04);
		ev(10'h040);
		chk(al, 8'h0c, "alarms");
		clr;
		wreg(ADDR_MODE, 8'h04);
		ev(10'h100);
		chk(al, 8'h00, "alarms");
		ev(10'h108);
		chk(al, 8'h02, "alarms");
		clr;
	endtask
	task automatic t_fan;
		wreg(ADDR_MODE, 8'h00);
		ev(10'h010);
		chk(al, 8'h04, "alarms");
		chk(act.coast, 1'b1, "coast");
		chk(act.overheat_warning_output, 1'b1, "ohw");
		clr;
		wreg(ADDR_MODE, 8'h20);
		ev(10'h010);
		chk(al, 8'h00, "alarms");
		chk(act.life_warning_output, 1'b1, "lifew");
		@(posedge clk) {fc, fs} <= 2'b11;
		@(posedge clk) fs <= 0;
		ev(10'h010);
		chk(act.overheat_warning_output, 1'b0, "ohw");
		rreg(ADDR_CTRL, 8'h02);
		@(posedge clk) st <= 1;
		@(posedge clk) st <= 0;
		ev(10'h010);
		chk(act.fan_run_cmd, 1'b1, "fan");
		chk(act.life_warning_output, 1'b1, "lifew");
		clr;
	endtask
	task automatic t_cfg;
		wreg(ADDR_MODE, 8'h88);
		ev(10'h006);
		chk(act.threshold_user, 1'b1, "thr");
		chk(act.sealed_enclosure, 1'b1, "encl");
		chk(al, 8'h00, "alarms");
		ev(10'h001);
		chk(al, 8'h20, "alarms");
		clr;
		wreg(ADDR_MODE, 8'h10);
		ev(10'h006);
		chk(act.threshold_user, 1'b0, "thr");
		chk(act.sealed_enclosure, 1'b0, "encl");
		chk(al, 8'h20, "alarms");
		clr;
	endtask
	task automatic give_verdict;
		if (errors == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			errors++;
			give_verdict;
		end
	end
	initial begin
		repeat (6) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		t_regs;
		t_in_loss;
		t_carrier;
		t_fan;
		t_cfg;
		give_verdict;
	end
endmodule // tb_drive_protection_mode_logic
